// ===== shared/gpo_pkg.sv
// Purpose: constants for the port override and register block
// Assumes: register index times four is the AXI byte address
// Notes:   port D data and direction live outside this block
package gpo_pkg;
	localparam int unsigned N_PORTS = 3;
	localparam int unsigned PORT_W  = 8;
	localparam int unsigned ADDR_W  = 8;
	localparam int unsigned IDX_LSB = 2;
	// register indices
	localparam logic [5:0] IDX_PIN_A = 6'h00;
	localparam logic [5:0] IDX_DIR_A = 6'h01;
	localparam logic [5:0] IDX_OUT_A = 6'h02;
	localparam logic [5:0] IDX_PIN_B = 6'h03;
	localparam logic [5:0] IDX_DIR_B = 6'h04;
	localparam logic [5:0] IDX_OUT_B = 6'h05;
	localparam logic [5:0] IDX_PIN_C = 6'h06;
	localparam logic [5:0] IDX_DIR_C = 6'h07;
	localparam logic [5:0] IDX_OUT_C = 6'h08;
	localparam logic [5:0] IDX_MCU   = 6'h35;
	// control register fields
	localparam int unsigned MCU_SCAN_BIT = 7;
	localparam int unsigned MCU_BOS_BIT  = 6;
	localparam int unsigned MCU_BOSU_BIT = 5;
	localparam int unsigned MCU_KILL_BIT = 4;
	localparam int unsigned MCU_VSEL_BIT = 1;
	localparam int unsigned MCU_VCU_BIT  = 0;
	localparam logic [7:0] MCU_RW_MASK = 8'h93;
	localparam logic [7:0] RST_BYTE    = 8'h00;
	// port D bit roles
	localparam int unsigned PD_RX  = 0;
	localparam int unsigned PD_TX  = 1;
	localparam int unsigned PD_CMP = 4;
	localparam int unsigned PD_CAP = 6;
	localparam int unsigned N_CMP  = 4;
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : gpo_pkg

// ===== rtl/gpo_port.sv
// Purpose: ports A-C registers and port D alternate-function overrides
// Assumes: one 10 MHz clock; pins are asynchronous and get synchronised
// Notes:   all outputs registered, so pins follow inputs one cycle late
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module gpo_port #(
	parameter int unsigned NP = gpo_pkg::N_PORTS
) (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst_b,
	// AXI4-Lite slave
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// ports A-C pins, port A in the low byte
	input  wire logic [NP*8-1:0]     abc_pin_in,
	output logic [NP*8-1:0]          abc_pin_out,
	output logic [NP*8-1:0]          abc_pin_oe,
	output logic [NP*8-1:0]          abc_pullup_on,
	// port D pins
	input  wire logic [7:0]          portd_pin_in,
	output logic [7:0]               portd_pin_out,
	output logic [7:0]               portd_pin_oe,
	output logic [7:0]               portd_pullup_on,
	output logic                     portd_slew_on,
	output logic                     portd_spike_filt_on,
	// port D register values
	input  wire logic [7:0]          portd_output_bits,
	input  wire logic [7:0]          portd_direction_bits,
	// peripheral controls
	input  wire logic                receiver_on,
	input  wire logic                transmitter_on,
	input  wire logic                twowire_on,
	input  wire logic                serial0_tx_data,
	input  wire logic [3:0]          cmp_wave_en,
	input  wire logic [3:0]          cmp_wave,
	input  wire logic [7:0]          pinchange_mask,
	input  wire logic                bank3_pinchange_en,
	input  wire logic                sleep_inbuf_off,
	input  wire logic                brownout_sleep,
	input  wire logic                brownout_sleep_unlock,
	// peripheral inputs
	output logic                     serial0_receive_pin,
	output logic                     timer3_ext_count_in,
	output logic                     timer1_capture_in,
	output logic [7:0]               pinchange_src,
	output logic                     pullup_kill,
	output logic                     scanport_disable,
	output logic                     vector_table_select,
	output logic                     vector_change_unlock
);
	localparam int unsigned W = NP * 8;

	// reset release
	logic rst_meta;
	logic rst_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta <= 1'b0;
			rst_q    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_q    <= rst_meta;
		end
	end

	// pin synchronisers; the first stage feeds only the second
	logic [W-1:0] abc_meta;
	logic [W-1:0] abc_sync;
	logic [7:0]   pd_meta;
	logic [7:0]   pd_sync;
	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			abc_meta <= '0;
			abc_sync <= '0;
			pd_meta  <= '0;
			pd_sync  <= '0;
		end else begin
			abc_meta <= abc_pin_in;
			abc_sync <= abc_meta;
			pd_meta  <= portd_pin_in;
			pd_sync  <= pd_meta;
		end
	end

	// register file state
	logic [NP-1:0][7:0] dir_reg, dir_next;
	logic [NP-1:0][7:0] out_reg, out_next;
	logic [7:0]         mcu_reg, mcu_next;
	// write channel state
	logic       awrdy_reg, awrdy_next;
	logic       wrdy_reg, wrdy_next;
	logic       aw_held_reg, aw_held_next;
	logic       w_held_reg, w_held_next;
	logic [7:0] aw_addr_reg, aw_addr_next;
	logic [7:0] w_byte_reg, w_byte_next;
	logic       w_lane_reg, w_lane_next;
	logic       bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	// read channel state
	logic        ardy_reg, ardy_next;
	logic        rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0]  rresp_reg, rresp_next;

	logic [7:0] mcu_view;
	logic       kill;
	assign kill     = mcu_reg[gpo_pkg::MCU_KILL_BIT];
	// read-only bits come live from the sleep logic
	assign mcu_view = (mcu_reg & gpo_pkg::MCU_RW_MASK)
		| {1'b0, brownout_sleep, brownout_sleep_unlock, 5'h00};

	function automatic logic known(input logic [5:0] ix);
		known = (ix == gpo_pkg::IDX_MCU);
		for (int p = 0; p < NP; p++) begin
			if (ix == 6'(3 * p) || ix == 6'(3 * p + 1)
				|| ix == 6'(3 * p + 2)) begin
				known = 1'b1;
			end
		end
	endfunction : known

	// register writes and reads
	always_comb begin
		logic [5:0] wix;
		logic [5:0] rix;
		logic       wr_go;
		wix          = aw_addr_reg[gpo_pkg::IDX_LSB +: 6];
		rix          = s_axi_araddr[gpo_pkg::IDX_LSB +: 6];
		wr_go        = aw_held_reg && w_held_reg && !bvalid_reg;
		dir_next     = dir_reg;
		out_next     = out_reg;
		mcu_next     = mcu_reg;
		aw_held_next = aw_held_reg;
		w_held_next  = w_held_reg;
		aw_addr_next = aw_addr_reg;
		w_byte_next  = w_byte_reg;
		w_lane_next  = w_lane_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg;
		rdata_next   = rdata_reg;
		rresp_next   = rresp_reg;
		if (s_axi_awvalid && awrdy_reg) begin
			aw_held_next = 1'b1;
			aw_addr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && wrdy_reg) begin
			w_held_next = 1'b1;
			w_byte_next = s_axi_wdata[7:0];
			w_lane_next = s_axi_wstrb[0];
		end
		if (s_axi_bvalid && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (wr_go) begin
			aw_held_next = 1'b0;
			w_held_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = known(wix) ? gpo_pkg::RESP_OKAY
				: gpo_pkg::RESP_SLVERR;
			for (int p = 0; p < NP; p++) begin
				if (w_lane_reg && wix == 6'(3 * p + 2)) begin
					out_next[p] = w_byte_reg;
				end
				if (w_lane_reg && wix == 6'(3 * p + 1)) begin
					dir_next[p] = w_byte_reg;
				end
				// ones written to the input register toggle the data bits
				if (w_lane_reg && wix == 6'(3 * p)) begin
					out_next[p] = out_reg[p] ^ w_byte_reg;
				end
			end
			if (w_lane_reg && wix == gpo_pkg::IDX_MCU) begin
				mcu_next = w_byte_reg & gpo_pkg::MCU_RW_MASK;
			end
		end
		awrdy_next = !aw_held_next && !bvalid_next;
		wrdy_next  = !w_held_next && !bvalid_next;
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		if (s_axi_arvalid && ardy_reg) begin
			rvalid_next = 1'b1;
			rdata_next  = '0;
			rresp_next  = known(rix) ? gpo_pkg::RESP_OKAY
				: gpo_pkg::RESP_SLVERR;
			for (int p = 0; p < NP; p++) begin
				if (rix == 6'(3 * p)) begin
					rdata_next[7:0] = abc_sync[p*8 +: 8];
				end
				if (rix == 6'(3 * p + 1)) begin
					rdata_next[7:0] = dir_reg[p];
				end
				if (rix == 6'(3 * p + 2)) begin
					rdata_next[7:0] = out_reg[p];
				end
			end
			if (rix == gpo_pkg::IDX_MCU) begin
				rdata_next[7:0] = mcu_view;
			end
		end
		ardy_next = !rvalid_next;
	end

	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			dir_reg     <= '0;
			out_reg     <= '0;
			mcu_reg     <= gpo_pkg::RST_BYTE;
			awrdy_reg   <= 1'b0;
			wrdy_reg    <= 1'b0;
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			aw_addr_reg <= '0;
			w_byte_reg  <= '0;
			w_lane_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= gpo_pkg::RESP_OKAY;
			ardy_reg    <= 1'b0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= '0;
			rresp_reg   <= gpo_pkg::RESP_OKAY;
		end else begin
			dir_reg     <= dir_next;
			out_reg     <= out_next;
			mcu_reg     <= mcu_next;
			awrdy_reg   <= awrdy_next;
			wrdy_reg    <= wrdy_next;
			aw_held_reg <= aw_held_next;
			w_held_reg  <= w_held_next;
			aw_addr_reg <= aw_addr_next;
			w_byte_reg  <= w_byte_next;
			w_lane_reg  <= w_lane_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			ardy_reg    <= ardy_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
		end
	end

	assign s_axi_awready = awrdy_reg;
	assign s_axi_wready  = wrdy_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = ardy_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	// port D override network, one bit per lane
	logic [7:0] pu_en, pu_val, dd_en, dd_val;
	logic [7:0] pv_en, pv_val, ie_en, ie_val;
	logic [7:0] pd_dir, pd_din;
	logic [W-1:0] abc_dir, abc_out;
	// next values of all pin-facing outputs
	logic [W-1:0] abc_oe_next, abc_out_next, abc_pu_next;
	logic [7:0] pd_oe_next, pd_out_next, pd_pu_next, pd_din_next;
	always_comb begin
		pu_en  = '0;
		pu_val = '0;
		dd_en  = '0;
		dd_val = '0;
		pv_en  = '0;
		pv_val = '0;
		pv_en[gpo_pkg::PD_CMP +: gpo_pkg::N_CMP]  = cmp_wave_en;
		pv_val[gpo_pkg::PD_CMP +: gpo_pkg::N_CMP] = cmp_wave;
		ie_en  = pinchange_mask & {8{bank3_pinchange_en}};
		ie_val = '1;
		pu_en[gpo_pkg::PD_TX]  = transmitter_on;
		pu_val[gpo_pkg::PD_TX] = portd_output_bits[gpo_pkg::PD_TX] & ~kill;
		dd_en[gpo_pkg::PD_TX]  = transmitter_on;
		dd_val[gpo_pkg::PD_TX] = 1'b1;
		pv_en[gpo_pkg::PD_TX]  = transmitter_on;
		pv_val[gpo_pkg::PD_TX] = serial0_tx_data;
		pu_en[gpo_pkg::PD_RX]  = receiver_on;
		// forced input keeps the data bit in charge of the pull-up
		pu_val[gpo_pkg::PD_RX] = portd_output_bits[gpo_pkg::PD_RX] & ~kill;
		dd_en[gpo_pkg::PD_RX]  = receiver_on;
		dd_val[gpo_pkg::PD_RX] = 1'b0;
		pd_dir = (dd_en & dd_val) | (~dd_en & portd_direction_bits);
		pd_oe_next  = pd_dir;
		pd_out_next = (pv_en & pv_val) | (~pv_en & portd_output_bits);
		pd_pu_next  = (pu_en & pu_val)
			| (~pu_en & ~portd_direction_bits & portd_output_bits
			& {8{~kill}});
		pd_din = pd_sync & ((ie_en & ie_val)
			| (~ie_en & {8{~sleep_inbuf_off}}));
		pd_din_next = pd_din;
		abc_dir      = dir_reg;
		abc_out      = out_reg;
		abc_oe_next  = abc_dir;
		abc_out_next = abc_out;
		abc_pu_next  = ~abc_dir & abc_out & {W{~kill}};
	end

	// every pin-facing output leaves through a flip-flop
	logic [W-1:0] abc_oe_reg, abc_out_reg, abc_pu_reg;
	logic [7:0] pd_oe_reg, pd_out_reg, pd_pu_reg, pd_din_reg;
	logic       twi_reg;
	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			abc_oe_reg  <= '0;
			abc_out_reg <= '0;
			abc_pu_reg  <= '0;
			pd_oe_reg   <= '0;
			pd_out_reg  <= '0;
			pd_pu_reg   <= '0;
			pd_din_reg  <= '0;
			twi_reg     <= 1'b0;
		end else begin
			abc_oe_reg  <= abc_oe_next;
			abc_out_reg <= abc_out_next;
			abc_pu_reg  <= abc_pu_next;
			pd_oe_reg   <= pd_oe_next;
			pd_out_reg  <= pd_out_next;
			pd_pu_reg   <= pd_pu_next;
			pd_din_reg  <= pd_din_next;
			twi_reg     <= twowire_on;
		end
	end

	assign abc_pin_oe          = abc_oe_reg;
	assign abc_pin_out         = abc_out_reg;
	assign abc_pullup_on       = abc_pu_reg;
	assign portd_pin_oe        = pd_oe_reg;
	assign portd_pin_out       = pd_out_reg;
	assign portd_pullup_on     = pd_pu_reg;
	assign portd_slew_on       = twi_reg;
	assign portd_spike_filt_on = twi_reg;
	assign serial0_receive_pin = pd_din_reg[gpo_pkg::PD_RX];
	assign timer3_ext_count_in = pd_din_reg[gpo_pkg::PD_RX];
	assign timer1_capture_in   = pd_din_reg[gpo_pkg::PD_CAP];
	assign pinchange_src       = pd_din_reg;
	assign pullup_kill         = kill;
	assign scanport_disable    = mcu_reg[gpo_pkg::MCU_SCAN_BIT];
	assign vector_table_select = mcu_reg[gpo_pkg::MCU_VSEL_BIT];
	assign vector_change_unlock = mcu_reg[gpo_pkg::MCU_VCU_BIT];

	// checks
	property p_rx_input;
		@(posedge clk) disable iff (!rst_q)
		receiver_on |=> !portd_pin_oe[gpo_pkg::PD_RX];
	endproperty
	a_rx_input: assert property (p_rx_input) else $error("rx driven");
	property p_rx_pullup;
		@(posedge clk) disable iff (!rst_q)
		receiver_on && portd_output_bits[gpo_pkg::PD_RX] && !kill
		|=> portd_pullup_on[gpo_pkg::PD_RX];
	endproperty
	a_rx_pullup: assert property (p_rx_pullup) else $error("rx pu");
	property p_t3_src;
		@(posedge clk) disable iff (!rst_q)
		##1 timer3_ext_count_in == $past(pd_din[gpo_pkg::PD_RX]);
	endproperty
	a_t3_src: assert property (p_t3_src) else $error("t3 wrong");
	property p_pc24;
		@(posedge clk) disable iff (!rst_q)
		##1 pinchange_src[0] == $past(pd_sync[0] & ~sleep_inbuf_off
			| pd_sync[0] & pinchange_mask[0] & bank3_pinchange_en);
	endproperty
	a_pc24: assert property (p_pc24) else $error("src 24 wrong");
	property p_cmp7;
		@(posedge clk) disable iff (!rst_q)
		cmp_wave_en[3] |=> portd_pin_out[7] == $past(cmp_wave[3]);
	endproperty
	a_cmp7: assert property (p_cmp7) else $error("cmp lost");
	property p_inbuf;
		@(posedge clk) disable iff (!rst_q)
		pinchange_mask[6] && bank3_pinchange_en
		|=> timer1_capture_in == $past(pd_sync[gpo_pkg::PD_CAP]);
	endproperty
	a_inbuf: assert property (p_inbuf) else $error("inbuf off");
	property p_twi;
		@(posedge clk) disable iff (!rst_q)
		twowire_on |=> portd_slew_on && portd_spike_filt_on;
	endproperty
	a_twi: assert property (p_twi) else $error("twi off");
	property p_kill;
		@(posedge clk) disable iff (!rst_q)
		kill && $stable(kill) |=> abc_pullup_on == '0
			&& portd_pullup_on == '0;
	endproperty
	a_kill: assert property (p_kill) else $error("pu on");
	property p_mcu_rsvd;
		@(posedge clk) disable iff (!rst_q)
		(mcu_view[3:2] == 2'h0) && !mcu_reg[gpo_pkg::MCU_BOS_BIT];
	endproperty
	a_mcu_rsvd: assert property (p_mcu_rsvd) else $error("rsvd");
	property p_tx_out;
		@(posedge clk) disable iff (!rst_q)
		transmitter_on |=> portd_pin_oe[gpo_pkg::PD_TX];
	endproperty
	a_tx_out: assert property (p_tx_out) else $error("tx undriven");
	property p_dir_oe;
		@(posedge clk) disable iff (!rst_q)
		##1 abc_pin_oe == $past(dir_reg);
	endproperty
	a_dir_oe: assert property (p_dir_oe) else $error("oe wrong");
endmodule : gpo_port

// ===== testbench/gpo_pin_model.sv
// Purpose: pin-level model of the pads around the port block
// Assumes: outside world drives ext levels on pins not driven by the block
// Notes:   pull-up wins over an undriven ext level; no bus contention model
`timescale 1ns/1ps
module gpo_pin_model (
	// block side
	input  wire logic [23:0] abc_out,
	input  wire logic [23:0] abc_oe,
	input  wire logic [23:0] abc_pu,
	input  wire logic [7:0]  d_out,
	input  wire logic [7:0]  d_oe,
	input  wire logic [7:0]  d_pu,
	// outside world
	input  wire logic [23:0] abc_ext,
	input  wire logic [7:0]  d_ext,
	// resolved pad levels
	output logic      [23:0] abc_in,
	output logic      [7:0]  d_in
);
	// driven pin shows its own value, else the pull-up, else the outside
	always_comb begin
		abc_in = (abc_oe & abc_out) | (~abc_oe & (abc_pu | abc_ext));
		d_in   = (d_oe & d_out) | (~d_oe & (d_pu | d_ext));
	end
endmodule : gpo_pin_model

// ===== testbench/gpo_port_tb_top.sv
// Purpose: self-checking bench for the port override and register block
// Assumes: AXI answers come when they come; bench waits under a timeout
// Notes:   pin checks wait a few edges to cover the input synchronisers
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
	n_fail++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module gpo_port_tb_top;
	logic        clk, rst_b;
	logic [7:0]  awaddr, araddr, d_out, d_oe, d_pu, d_in, d_ext, pmask;
	logic [7:0]  dbits, ddir, psrc;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb, cen, cwave;
	logic [1:0]  bresp, rresp, resp;
	logic [23:0] a_out, a_oe, a_pu, a_in, a_ext;
	logic        rx_on, tx_on, tw_on, txd, bank3, sleep_off, bos, bosu;
	logic        slew, spike, rxp, t3, cap, kill, scan, vsel, vcu;
	logic [7:0]  rd;
	int          n_fail, check_count, cyc;

	gpo_port #(.NP(3)) i_dut (.clk(clk), .rst_b(rst_b),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.abc_pin_in(a_in), .abc_pin_out(a_out), .abc_pin_oe(a_oe),
		.abc_pullup_on(a_pu), .portd_pin_in(d_in), .portd_pin_out(d_out),
		.portd_pin_oe(d_oe), .portd_pullup_on(d_pu), .portd_slew_on(slew),
		.portd_spike_filt_on(spike), .portd_output_bits(dbits),
		.portd_direction_bits(ddir), .receiver_on(rx_on),
		.transmitter_on(tx_on), .twowire_on(tw_on), .serial0_tx_data(txd),
		.cmp_wave_en(cen), .cmp_wave(cwave), .pinchange_mask(pmask),
		.bank3_pinchange_en(bank3), .sleep_inbuf_off(sleep_off),
		.brownout_sleep(bos), .brownout_sleep_unlock(bosu),
		.serial0_receive_pin(rxp), .timer3_ext_count_in(t3),
		.timer1_capture_in(cap), .pinchange_src(psrc), .pullup_kill(kill),
		.scanport_disable(scan), .vector_table_select(vsel),
		.vector_change_unlock(vcu));
	gpo_pin_model i_pins (.abc_out(a_out), .abc_oe(a_oe), .abc_pu(a_pu),
		.d_out(d_out), .d_oe(d_oe), .d_pu(d_pu), .abc_ext(a_ext),
		.d_ext(d_ext), .abc_in(a_in), .d_in(d_in));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic summarize;
		if (n_fail == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : summarize

	// hang guard: whole run needs under two hundred cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			summarize();
		end
	end

	// address and data offered together, each released when taken
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok  = 1'b0;
		@(posedge clk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		wdata   <= {24'h000000, d};
		wstrb   <= 4'hF;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge clk);
		rd = rdata[7:0];
		resp = rresp;
		`CHK("rdata high", 24'h000000, rdata[31:8])
		rready <= 1'b0;
	endtask : axi_rd

	// pins need two sync edges plus the output register
	task automatic settle;
		repeat (4) @(posedge clk);
	endtask : settle

	task automatic t_reset;
		logic [7:0] idx [6] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h07, 8'h08};
		foreach (idx[i]) begin
			axi_rd(idx[i] << 2);
			`CHK("reset reg", 8'h00, rd)
		end
		axi_rd(8'hD4);
		`CHK("ctrl reset", 8'h00, rd)
		axi_rd(8'h24);
		`CHK("unmapped resp", gpo_pkg::RESP_SLVERR, resp)
		`CHK("unmapped data", 8'h00, rd)
		axi_wr(8'h24, 8'hFF);
		`CHK("unmapped wr resp", gpo_pkg::RESP_SLVERR, resp)
	endtask : t_reset

	task automatic t_regs;
		axi_wr(8'h04, 8'hF0);
		axi_wr(8'h08, 8'hAA);
		axi_wr(8'h10, 8'h0F);
		axi_wr(8'h14, 8'h3C);
		axi_rd(8'h08);
		`CHK("data A", 8'hAA, rd)
		axi_rd(8'h10);
		`CHK("dir B", 8'h0F, rd)
		settle();
		`CHK("oe A", 8'hF0, a_oe[7:0])
		`CHK("out A", 8'hAA, a_out[7:0])
		`CHK("pu A", 8'h0A, a_pu[7:0])
		`CHK("pu B", 8'h30, a_pu[15:8])
		bos <= 1'b1;
		axi_wr(8'hD4, 8'hFF);
		`CHK("ctrl wr resp", gpo_pkg::RESP_OKAY, resp)
		axi_rd(8'hD4);
		`CHK("ctrl read", 8'hD3, rd)
		bosu <= 1'b1;
		axi_rd(8'hD4);
		`CHK("ctrl read ro", 8'hF3, rd)
		bosu <= 1'b0;
		settle();
		`CHK("ctrl outs", 4'hF, {kill, scan, vsel, vcu})
		`CHK("pu killed", 24'h000000, a_pu)
		axi_wr(8'hD4, 8'h00);
		bos <= 1'b0;
	endtask : t_regs

	task automatic t_pinread;
		a_ext <= 24'h5A0000;
		axi_wr(8'h1C, 8'h00);
		axi_wr(8'h20, 8'h01);
		settle();
		axi_rd(8'h18);
		`CHK("pin C", 8'h5B, rd)
		// ones written to the pin register toggle the data bits
		axi_wr(8'h18, 8'h03);
		axi_rd(8'h20);
		`CHK("toggle C", 8'h02, rd)
	endtask : t_pinread

	task automatic t_portd;
		ddir  <= 8'h01;
		dbits <= 8'h00;
		rx_on <= 1'b1;
		d_ext <= 8'h41;
		settle();
		`CHK("rx oe", 1'b0, d_oe[0])
		`CHK("rx pin", 3'b111, {rxp, t3, psrc[0]})
		dbits <= 8'h01;
		d_ext <= 8'h40;
		settle();
		`CHK("rx pu", 1'b1, d_pu[0])
		ddir  <= 8'hF0;
		tx_on <= 1'b1;
		txd   <= 1'b1;
		cen   <= 4'b1101;
		cwave <= 4'b1111;
		tw_on <= 1'b1;
		settle();
		`CHK("tx oe", 1'b1, d_oe[1])
		`CHK("tx val", 1'b1, d_out[1])
		`CHK("cmp out", 4'b1101, d_out[7:4])
		`CHK("cmp oe", 4'hF, d_oe[7:4])
		`CHK("twi", 2'b11, {slew, spike})
		ddir      <= 8'h00;
		sleep_off <= 1'b1;
		settle();
		`CHK("cap off", 1'b0, cap)
		pmask <= 8'h40;
		bank3 <= 1'b1;
		settle();
		`CHK("cap forced", 1'b1, cap)
	endtask : t_portd

	initial begin
		n_fail      = 0;
		check_count = 0;
		cyc         = 0;
		rst_b       = 1'b0;
		awaddr      = 8'h00;
		awvalid     = 1'b0;
		wdata       = 32'h00000000;
		wstrb       = 4'h0;
		wvalid      = 1'b0;
		bready      = 1'b0;
		araddr      = 8'h00;
		arvalid     = 1'b0;
		rready      = 1'b0;
		a_ext       = 24'h000000;
		d_ext       = 8'h00;
		dbits       = 8'h00;
		ddir        = 8'h00;
		rx_on       = 1'b0;
		tx_on       = 1'b0;
		tw_on       = 1'b0;
		txd         = 1'b0;
		cen         = 4'h0;
		cwave       = 4'h0;
		pmask       = 8'h00;
		bank3       = 1'b0;
		sleep_off   = 1'b0;
		bos         = 1'b0;
		bosu        = 1'b0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		repeat (5) @(posedge clk);
		t_reset();
		t_regs();
		t_pinread();
		t_portd();
		summarize();
	end
endmodule : gpo_port_tb_top
